/* File: core/lrr_pkg.sv */
// Shared constants for the link rate and error register group and its controller.
// Assumes a 20 MHz system clock on both ends.
package lrr_pkg;
  // Clocking
  localparam int CLK_MHZ         = 20;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int HOLD_NS         = 2000;
  localparam int HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CTL_TO_SHORT_US = 1000;
  localparam int CTL_TO_LONG_US  = 1000000;
  localparam int INIT_EDGES      = 16;
  localparam int LCLK_HALF       = 4;

  // Config space offsets and fields of the device
  localparam logic [7:0] OFS_RATE0   = 8'h09;
  localparam logic [7:0] OFS_CAP0_LO = 8'h0A;
  localparam logic [7:0] OFS_CAP0_HI = 8'h0B;
  localparam int         RATE_LSB    = 0;
  localparam int         ERR_PROTO   = 4;
  localparam int         ERR_OVF     = 5;
  localparam int         ERR_EOC     = 6;
  localparam int         CTL_TO_SEL  = 7;

  // Capability and defaults
  localparam logic [15:0] CAP_MASK        = 16'h007F;
  localparam logic        VENDOR_RATES    = 1'b0;
  localparam logic [4:0]  CODE_AC_DEFAULT = 5'h07;
  localparam logic [4:0]  THIRD_GENERATION_PROTOCOL_MIN_CODE   = 5'h07;
  localparam logic [15:0] RETRAIN_US_DEF  = 16'h00C8;

  // Controller AXI4-Lite register offsets
  localparam logic [3:0] CTL_CMD   = 4'h0;
  localparam logic [3:0] CTL_STAT  = 4'h4;
  localparam logic [3:0] CTL_LINK  = 4'h8;
  localparam logic [3:0] CTL_TRAIN = 4'hC;
  localparam int CMD_WR  = 16;
  localparam int LNK_RST = 0;
  localparam int LNK_STP = 1;
  localparam int LNK_HWM = 2;
  localparam int LNK_CTL = 3;
  localparam int LNK_RATE = 4;

  typedef enum logic [3:0] {
    LRR_DOWN  = 4'h1,
    LRR_HOLD  = 4'h2,
    LRR_TRAIN = 4'h4,
    LRR_UP    = 4'h8
  } lrr_state_t;

  // Transmitter clock in MHz for a 5-bit code; zero for reserved or vendor codes
  function automatic logic [11:0] rate_mhz(input logic [4:0] code);
    case (code)
      5'h00: rate_mhz = 12'h0C8;
      5'h01: rate_mhz = 12'h12C;
      5'h02: rate_mhz = 12'h190;
      5'h03: rate_mhz = 12'h1F4;
      5'h04: rate_mhz = 12'h258;
      5'h05: rate_mhz = 12'h320;
      5'h06: rate_mhz = 12'h3E8;
      5'h07: rate_mhz = 12'h4B0;
      5'h08: rate_mhz = 12'h578;
      5'h09: rate_mhz = 12'h640;
      5'h0A: rate_mhz = 12'h708;
      5'h0B: rate_mhz = 12'h7D0;
      5'h0C: rate_mhz = 12'h898;
      5'h0D: rate_mhz = 12'h960;
      5'h0E: rate_mhz = 12'hA28;
      5'h11: rate_mhz = 12'hAF0;
      5'h12: rate_mhz = 12'hBB8;
      5'h13: rate_mhz = 12'hC80;
      default: rate_mhz = 12'h000;
    endcase
  endfunction
endpackage

/* File: core/lrr_if.sv */
// Link between the rate/error register device and its controller.
// Assumes the testbench joins both ends; no tristate wires.
`timescale 1ns/1ps
`default_nettype none
interface lrr_if;
  // Link pins
  logic       link_clk;
  logic       link_reset_n;
  logic       link_stop_pin_n;
  logic       link_control_line;
  logic [4:0] peer_rate;
  // Config space byte access
  logic       cfg_valid;
  logic       cfg_ready;
  logic       cfg_write;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic       cfg_done;
  logic [7:0] cfg_rdata;

  modport dev (input link_clk, link_reset_n, link_stop_pin_n, link_control_line, peer_rate,
               cfg_valid, cfg_write, cfg_addr, cfg_wdata,
               output cfg_ready, cfg_done, cfg_rdata);
  modport ctl (output link_clk, link_reset_n, link_stop_pin_n, link_control_line, peer_rate,
               cfg_valid, cfg_write, cfg_addr, cfg_wdata,
               input cfg_ready, cfg_done, cfg_rdata);
endinterface
`default_nettype wire

/* File: core/lrr_dev.sv */
// Device end: rate select, error log and rate capability registers for one link.
// Assumes link pins come from another clock domain and error events are same-clock pulses.
`timescale 1ns/1ps
`default_nettype none
module lrr_dev #(
  parameter int CTL_TO_SHORT_CYC = lrr_pkg::CTL_TO_SHORT_US * lrr_pkg::CLK_MHZ,
  parameter int CTL_TO_LONG_CYC  = lrr_pkg::CTL_TO_LONG_US * lrr_pkg::CLK_MHZ
) (
  // Clock and cold reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Link side
  lrr_if.dev               lnk,
  // Straps and mode
  input  wire logic        ac_coupled,
  input  wire logic        clocking_sync,
  input  wire logic        rate_code_extension_bit,
  // Error events from the link logic
  input  wire logic        proto_err_evt,
  input  wire logic        overflow_evt,
  input  wire logic        eoc_evt,
  // Status
  output logic             link_up,
  output logic             rate_mismatch,
  output logic [4:0]       tx_rate_code,
  output logic [11:0]      tx_rate_mhz,
  output logic             tx_rate_exact
);
  // Synchronisers: first stage is read only by the second
  logic [4:0] s1_q, s2_q;
  logic [4:0] pr1_q, pr2_q;
  logic       lclk_last_q;
  // Idle pin levels: clock low, control high, stop and reset deasserted; avoids a false warm reset
  localparam logic [4:0] SYNC_IDLE = 5'h0E;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q        <= SYNC_IDLE;
      s2_q        <= SYNC_IDLE;
      pr1_q       <= 5'h00;
      pr2_q       <= 5'h00;
      lclk_last_q <= 1'b0;
    end else begin
      s1_q        <= {lnk.link_clk, lnk.link_control_line, lnk.link_stop_pin_n, lnk.link_reset_n, 1'b0};
      s2_q        <= s1_q;
      pr1_q       <= lnk.peer_rate;
      pr2_q       <= pr1_q;
      lclk_last_q <= s2_q[4];
    end
  end

  logic rst_n_s, stop_n_s, ctl_s, lclk_rise;
  assign rst_n_s   = s2_q[1];
  assign stop_n_s  = s2_q[2];
  assign ctl_s     = s2_q[3];
  assign lclk_rise = s2_q[4] && !lclk_last_q;

  // Register and link state
  logic [3:0]          rate_q, rate_d;
  logic [2:0]          err_q, err_d;
  logic                to_sel_q, to_sel_d;
  logic [4:0]          appl_q, appl_d;
  logic                strap_q, strap_d;
  lrr_pkg::lrr_state_t st_q, st_d;
  logic [24:0]         cnt_q, cnt_d;
  logic                mism_q, mism_d;
  logic                ack_q, ack_d;
  logic [7:0]          rdata_q, rdata_d;
  logic [15:0]         cap;
  logic [2:0]          set_evt, clr_evt;
  logic                to_hit;

  // Capability mask with the mandatory and vendor bits forced
  assign cap = {lrr_pkg::VENDOR_RATES, lrr_pkg::CAP_MASK[14:1], 1'b1};

  // Control-low timeout reached while the link is up
  assign to_hit = (st_q == lrr_pkg::LRR_UP) && !ctl_s &&
                  (cnt_q >= (to_sel_q ? 25'(CTL_TO_LONG_CYC) : 25'(CTL_TO_SHORT_CYC)));

  always_comb begin
    rate_d   = rate_q;
    err_d    = err_q;
    to_sel_d = to_sel_q;
    appl_d   = appl_q;
    strap_d  = 1'b1;
    st_d     = st_q;
    cnt_d    = cnt_q;
    mism_d   = mism_q;
    ack_d    = 1'b0;
    rdata_d  = rdata_q;
    clr_evt  = 3'b000;
    // AC-coupled strap caught on the first clock after cold reset
    if (!strap_q) begin
      appl_d = ac_coupled ? lrr_pkg::CODE_AC_DEFAULT : 5'h00;
    end
    // Config byte access; only the first link copy is built
    if (lnk.cfg_valid) begin
      ack_d = 1'b1;
      if (lnk.cfg_addr == lrr_pkg::OFS_RATE0) begin
        if (lnk.cfg_write) begin
          rate_d   = lnk.cfg_wdata[lrr_pkg::RATE_LSB +: 4];
          to_sel_d = lnk.cfg_wdata[lrr_pkg::CTL_TO_SEL];
          clr_evt  = lnk.cfg_wdata[lrr_pkg::ERR_EOC:lrr_pkg::ERR_PROTO];
        end else begin
          rdata_d = {to_sel_q, err_q, rate_q};
        end
      end else if (lnk.cfg_addr == lrr_pkg::OFS_CAP0_LO) begin
        rdata_d = lnk.cfg_write ? rdata_q : cap[7:0];
      end else if (lnk.cfg_addr == lrr_pkg::OFS_CAP0_HI) begin
        rdata_d = lnk.cfg_write ? rdata_q : cap[15:8];
      end else begin
        rdata_d = lnk.cfg_write ? rdata_q : 8'h00;
      end
    end
    // Log bits: a set in the same cycle as a clear wins
    set_evt = {eoc_evt, overflow_evt, proto_err_evt || to_hit};
    err_d   = (err_q & ~clr_evt) | set_evt;
    // Warm reset clears the timeout select
    if (!rst_n_s) begin
      to_sel_d = 1'b0;
    end
    // Link bring-up sequence
    case (st_q)
      lrr_pkg::LRR_UP,
      lrr_pkg::LRR_TRAIN: begin
        if (!rst_n_s || !stop_n_s) begin
          st_d  = lrr_pkg::LRR_HOLD;
          cnt_d = 25'h0000000;
        end else if (st_q == lrr_pkg::LRR_TRAIN) begin
          mism_d = (pr2_q != appl_q);
          if (pr2_q != appl_q) begin
            cnt_d = 25'h0000000;
          end else if (lclk_rise && ctl_s) begin
            cnt_d = cnt_q + 25'h0000001;
            if (cnt_q == 25'(lrr_pkg::INIT_EDGES - 1)) begin
              st_d  = lrr_pkg::LRR_UP;
              cnt_d = 25'h0000000;
            end
          end
        end else begin
          cnt_d = ctl_s ? 25'h0000000 : cnt_q + 25'h0000001;
          if (to_hit) begin
            cnt_d = 25'h0000000;
          end
        end
      end
      lrr_pkg::LRR_HOLD: begin
        // Old rate kept for a while so a late-seeing peer still receives cleanly
        cnt_d = cnt_q + 25'h0000001;
        if (cnt_q == 25'(lrr_pkg::HOLD_CYC - 1)) begin
          appl_d = {rate_code_extension_bit, rate_q};
          st_d   = lrr_pkg::LRR_DOWN;
          cnt_d  = 25'h0000000;
        end
      end
      lrr_pkg::LRR_DOWN: begin
        if (rst_n_s && stop_n_s) begin
          st_d = lrr_pkg::LRR_TRAIN;
        end
      end
      default: begin
        st_d = lrr_pkg::LRR_DOWN;
      end
    endcase
  end

  // Registers; cold reset only, warm effects handled above
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rate_q   <= 4'h0;
      err_q    <= 3'b000;
      to_sel_q <= 1'b0;
      appl_q   <= 5'h00;
      strap_q  <= 1'b0;
      st_q     <= lrr_pkg::LRR_DOWN;
      cnt_q    <= 25'h0000000;
      mism_q   <= 1'b0;
      ack_q    <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      rate_q   <= rate_d;
      err_q    <= err_d;
      to_sel_q <= to_sel_d;
      appl_q   <= appl_d;
      strap_q  <= strap_d;
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      mism_q   <= mism_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
    end
  end

  // Outputs
  assign lnk.cfg_ready = 1'b1;
  assign lnk.cfg_done  = ack_q;
  assign lnk.cfg_rdata = rdata_q;
  assign link_up       = (st_q == lrr_pkg::LRR_UP);
  assign rate_mismatch = mism_q;
  assign tx_rate_code  = appl_q;
  assign tx_rate_mhz   = lrr_pkg::rate_mhz(appl_q);
  assign tx_rate_exact = clocking_sync;
endmodule // lrr_dev
`default_nettype wire

/* File: core/lrr_ctl.sv */
// Controller end: AXI4-Lite registers that drive config accesses and the link pins.
// Assumes software programs both ends to the same rate code.
`timescale 1ns/1ps
`default_nettype none
module lrr_ctl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link side
  lrr_if.ctl               lnk,
  // Link mode outputs
  output logic             retry_enable,
  output logic             scramble_enable,
  output logic [15:0]      retrain_wait_time
);
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [3:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [8:0]  link_q, link_d;
  logic [15:0] trn_q, trn_d;
  logic        busy_q, busy_d, wr_q, wr_d, ref_q, ref_d;
  logic [7:0]  ad_q, ad_d, wb_q, wb_d, cr_q, cr_d;
  logic [4:0]  peer_q, peer_d;
  logic [2:0]  div_q, div_d;
  logic        lclk_q, lclk_d;
  logic        rst_pin_n;

  // Reset held off while a config access is in flight
  assign rst_pin_n = !(link_q[lrr_pkg::LNK_RST] && !busy_q);

  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
    awa_d = awa_q; wd_d = wd_q; rd_d = rd_q;
    link_d = link_q; trn_d = trn_q; busy_d = busy_q; wr_d = wr_q; ref_d = ref_q;
    ad_d = ad_q; wb_d = wb_q; cr_d = cr_q; peer_d = peer_q;
    // Link clock divider
    div_d  = (div_q == 3'(lrr_pkg::LCLK_HALF - 1)) ? 3'h0 : div_q + 3'h1;
    lclk_d = (div_q == 3'(lrr_pkg::LCLK_HALF - 1)) ? !lclk_q : lclk_q;
    // Own rate takes effect while the reset pin is asserted
    if (!rst_pin_n) begin
      peer_d = link_q[lrr_pkg::LNK_RATE +: 5];
    end
    // Config access completes on the device's done pulse
    if (busy_q && lnk.cfg_done) begin
      busy_d = 1'b0;
      cr_d   = lnk.cfg_rdata;
    end
    // Write channels taken in either order
    if (s_axi_awvalid && !aw_q && !b_q) begin
      aw_d = 1'b1; awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !b_q) begin
      w_d = 1'b1; wd_d = s_axi_wdata;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1;
      if (awa_q == lrr_pkg::CTL_CMD) begin
        // Rate byte stays untouched once hardware management runs
        if (busy_q) begin
          ref_d = 1'b1;
        end else if (link_q[lrr_pkg::LNK_HWM] && wd_q[lrr_pkg::CMD_WR] && wd_q[7:0] == lrr_pkg::OFS_RATE0) begin
          ref_d = 1'b1;
        end else begin
          busy_d = 1'b1; ad_d = wd_q[7:0]; wb_d = wd_q[15:8]; wr_d = wd_q[lrr_pkg::CMD_WR];
        end
      end else if (awa_q == lrr_pkg::CTL_STAT) begin
        ref_d = ref_q && !wd_q[9];
      end else if (awa_q == lrr_pkg::CTL_LINK) begin
        link_d = wd_q[8:0];
      end else if (awa_q == lrr_pkg::CTL_TRAIN) begin
        trn_d = wd_q[15:0];
      end
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    // Read channel
    if (s_axi_arvalid && !r_q) begin
      r_d = 1'b1;
      if (s_axi_araddr == lrr_pkg::CTL_STAT) begin
        rd_d = {22'h000000, ref_q, busy_q, cr_q};
      end else if (s_axi_araddr == lrr_pkg::CTL_LINK) begin
        rd_d = {23'h000000, link_q};
      end else if (s_axi_araddr == lrr_pkg::CTL_TRAIN) begin
        rd_d = {16'h0000, trn_q};
      end else begin
        rd_d = 32'h00000000;
      end
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 4'h0; wd_q <= 32'h00000000; rd_q <= 32'h00000000;
      link_q <= 9'h000; trn_q <= lrr_pkg::RETRAIN_US_DEF;
      busy_q <= 1'b0; wr_q <= 1'b0; ref_q <= 1'b0;
      ad_q <= 8'h00; wb_q <= 8'h00; cr_q <= 8'h00; peer_q <= 5'h00;
      div_q <= 3'h0; lclk_q <= 1'b0;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
      link_q <= link_d; trn_q <= trn_d;
      busy_q <= busy_d; wr_q <= wr_d; ref_q <= ref_d;
      ad_q <= ad_d; wb_q <= wb_d; cr_q <= cr_d; peer_q <= peer_d;
      div_q <= div_d; lclk_q <= lclk_d;
    end
  end

  // AXI handshakes
  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = 2'h0;
  // Link pins; the stop pin is also held off during a config access
  assign lnk.link_clk          = lclk_q;
  assign lnk.link_reset_n      = rst_pin_n;
  assign lnk.link_stop_pin_n   = !(link_q[lrr_pkg::LNK_STP] && !busy_q);
  assign lnk.link_control_line = rst_pin_n && !link_q[lrr_pkg::LNK_CTL];
  assign lnk.peer_rate         = peer_q;
  assign lnk.cfg_valid         = busy_q;
  assign lnk.cfg_write         = wr_q;
  assign lnk.cfg_addr          = ad_q;
  assign lnk.cfg_wdata         = wb_q;
  // Third-generation rates need retry and scrambling
  assign retry_enable      = (link_q[lrr_pkg::LNK_RATE +: 5] >= lrr_pkg::THIRD_GENERATION_PROTOCOL_MIN_CODE);
  assign scramble_enable   = (link_q[lrr_pkg::LNK_RATE +: 5] >= lrr_pkg::THIRD_GENERATION_PROTOCOL_MIN_CODE);
  assign retrain_wait_time = trn_q;
endmodule // lrr_ctl
`default_nettype wire

/* File: bench/lrr_props.sv */
// Checker for the config and pin traffic between the controller and device ends.
// Assumes the testbench instantiates it beside the interface that joins the two ends.
`timescale 1ns/1ps
`default_nettype none
module lrr_props (
  // Clock and cold reset
  input wire logic       clock,
  input wire logic       resetn,
  // Link pins
  input wire logic       link_clk,
  input wire logic       link_reset_n,
  input wire logic       link_stop_pin_n,
  input wire logic       link_control_line,
  input wire logic [4:0] peer_rate,
  // Config byte access
  input wire logic       cfg_valid,
  input wire logic       cfg_ready,
  input wire logic       cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic       cfg_done,
  input wire logic [7:0] cfg_rdata
);
  logic [3:0] rate_q;
  logic [3:0] rate_d;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Shadow of the rate field; only cold reset and config writes move it
  always_comb begin
    rate_d = rate_q;
    if (cfg_valid && cfg_write && cfg_addr == lrr_pkg::OFS_RATE0) begin
      rate_d = cfg_wdata[3:0];
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rate_q <= 4'h0;
    end else begin
      rate_q <= rate_d;
    end
  end

  property p_cap_lo;
    cfg_valid && !cfg_write && cfg_addr == lrr_pkg::OFS_CAP0_LO |=> cfg_done && cfg_rdata == 8'h7F;
  endproperty
  a_cap_lo: assert property (p_cap_lo) else $error("capability low byte wrong");
  property p_cap_hi;
    cfg_valid && !cfg_write && cfg_addr == lrr_pkg::OFS_CAP0_HI |=> cfg_done && cfg_rdata == 8'h00;
  endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("capability high byte wrong");
  property p_rsv;
    cfg_valid && !cfg_write && (cfg_addr == 8'h0D || cfg_addr == 8'h11) |=> cfg_rdata == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved copy not zero");
  property p_rate_rd;
    cfg_valid && !cfg_write && cfg_addr == lrr_pkg::OFS_RATE0 |=> cfg_rdata[3:0] == rate_q;
  endproperty
  a_rate_rd: assert property (p_rate_rd) else $error("rate field lost its value");
  property p_pins_idle;
    cfg_valid |-> link_reset_n && link_stop_pin_n;
  endproperty
  a_pins_idle: assert property (p_pins_idle) else $error("pin asserted during access");
  property p_peer_hold;
    $changed(peer_rate) |-> !link_reset_n || !$past(link_reset_n);
  endproperty
  a_peer_hold: assert property (p_peer_hold) else $error("peer rate moved outside reset");
  property p_done_src;
    cfg_done |-> $past(cfg_valid && cfg_ready);
  endproperty
  a_done_src: assert property (p_done_src) else $error("done without request");
  property p_lclk;
    $changed(link_clk) |=> $stable(link_clk) [*3];
  endproperty
  a_lclk: assert property (p_lclk) else $error("link clock half period short");
endmodule // lrr_props
`default_nettype wire

/* File: bench/testbench.sv */
// Testbench joining controller and device ends through the link interface.
// Assumes AXI4-Lite answers as the controller's hand-over states; shortened timeouts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Clock, reset, straps and events
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        ac_coupled = 1'b1;
  logic        clocking_sync = 1'b0;
  logic        rate_code_extension_bit = 1'b0;
  logic [2:0]  evt = 3'h0;
  // AXI4-Lite master
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  // Status outputs
  logic        link_up, rate_mismatch, tx_rate_exact, retry_enable, scramble_enable;
  logic [4:0]  tx_rate_code;
  logic [11:0] tx_rate_mhz;
  logic [15:0] retrain_wait_time;
  // Bench state
  int          mismatches = 0, checked = 0, seed = 61799, tmp;
  logic [4:0]  cur, code;
  logic [7:0]  regv;
  logic [31:0] rd;

  always #25 clock = ~clock;

  lrr_if lnk_if ();
  lrr_dev #(.CTL_TO_SHORT_CYC(50), .CTL_TO_LONG_CYC(200)) lrr_dev_inst (.clock(clock), .resetn(resetn),
    .lnk(lnk_if), .ac_coupled(ac_coupled), .clocking_sync(clocking_sync),
    .rate_code_extension_bit(rate_code_extension_bit), .proto_err_evt(evt[0]), .overflow_evt(evt[1]),
    .eoc_evt(evt[2]), .link_up(link_up), .rate_mismatch(rate_mismatch), .tx_rate_code(tx_rate_code),
    .tx_rate_mhz(tx_rate_mhz), .tx_rate_exact(tx_rate_exact));
  lrr_ctl lrr_ctl_inst (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lnk(lnk_if),
    .retry_enable(retry_enable), .scramble_enable(scramble_enable), .retrain_wait_time(retrain_wait_time));
  lrr_props lrr_props_inst (.clock(clock), .resetn(resetn), .link_clk(lnk_if.link_clk),
    .link_reset_n(lnk_if.link_reset_n), .link_stop_pin_n(lnk_if.link_stop_pin_n),
    .link_control_line(lnk_if.link_control_line), .peer_rate(lnk_if.peer_rate), .cfg_valid(lnk_if.cfg_valid),
    .cfg_ready(lnk_if.cfg_ready), .cfg_write(lnk_if.cfg_write), .cfg_addr(lnk_if.cfg_addr),
    .cfg_wdata(lnk_if.cfg_wdata), .cfg_done(lnk_if.cfg_done), .cfg_rdata(lnk_if.cfg_rdata));

  // Expected transmitter clock in MHz; the table is piecewise linear
  function automatic logic [11:0] exp_mhz(input logic [4:0] c);
    if (c <= 5'h04) return 12'(200 + 100 * c);
    if (c <= 5'h0E) return 12'(200 * c - 200);
    if (c >= 5'h11 && c <= 5'h13) return 12'(200 * c - 600);
    return 12'h000;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        b_ok = 1'b1;
        bready <= 1'b0;
      end
    end
    @(posedge clock);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(posedge clock);
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        r_ok = 1'b1;
        d = rdata;
        rready <= 1'b0;
      end
    end
    @(posedge clock);
  endtask

  // One device access through the controller; returns the status word once idle
  task automatic cfg(input logic [7:0] a, input logic w, input logic [7:0] b, output logic [31:0] st);
    int n;
    axi_wr(lrr_pkg::CTL_CMD, {15'h0, w, b, a});
    n = 0;
    st = 32'h100;
    while (st[8] !== 1'b0 && n < 50) begin
      repeat (2) @(posedge clock);
      axi_rd(lrr_pkg::CTL_STAT, st);
      n++;
    end
  endtask

  // Pulse reset or stop pin, then wait for training to settle
  task automatic link_cycle(input int b, input logic [4:0] dc, input logic [4:0] oc);
    int n;
    axi_wr(lrr_pkg::CTL_LINK, {23'h0, oc, 4'h0} | (32'h1 << b));
    repeat (30) @(posedge clock);
    check(tx_rate_code, cur);
    repeat (50) @(posedge clock);
    axi_wr(lrr_pkg::CTL_LINK, {23'h0, oc, 4'h0});
    cur = dc;
    n = 0;
    while (link_up !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(tx_rate_code, dc);
    check(link_up, dc == oc);
    check(rate_mismatch, dc != oc);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    check(tx_rate_code, 5'h07);
    check(tx_rate_mhz, 12'h4B0);
    check(retrain_wait_time, 16'h00C8);
    ac_coupled <= 1'b0;
    cur = 5'h07;
    cfg(lrr_pkg::OFS_RATE0, 1'b0, 8'h00, rd);
    check(rd[7:0], 8'h00);
    cfg(lrr_pkg::OFS_CAP0_LO, 1'b0, 8'h00, rd);
    check(rd[7:0], 8'h7F);
    cfg(lrr_pkg::OFS_CAP0_HI, 1'b0, 8'h00, rd);
    check(rd[7:0], 8'h00);
    cfg(8'h0D, 1'b0, 8'h00, rd);
    check(rd[7:0], 8'h00);
    $display("end of test: reset values");
    // Corner codes first, then random supported codes; last pass uses the stop pin
    for (int i = 0; i < 6; i++) begin
      tmp = {$random(seed)} % 18;
      code = (i == 0) ? 5'h13 : (i == 1) ? 5'h00 : (i == 5) ? cur : (tmp < 15) ? 5'(tmp) : 5'(tmp + 2);
      regv = {1'($random(seed)), 3'h0, code[3:0]};
      rate_code_extension_bit <= code[4];
      clocking_sync <= 1'($random(seed));
      cfg(lrr_pkg::OFS_RATE0, 1'b1, regv, rd);
      link_cycle((i == 5) ? lrr_pkg::LNK_STP : lrr_pkg::LNK_RST, code, code);
      regv[7] = (i == 5) ? regv[7] : 1'b0;
      check(tx_rate_mhz, exp_mhz(code));
      check(tx_rate_exact, clocking_sync);
      check(retry_enable, code >= 5'h07);
      check(scramble_enable, code >= 5'h07);
      cfg(lrr_pkg::OFS_RATE0, 1'b0, 8'h00, rd);
      check(rd[7:0], regv);
    end
    $display("end of test: rate changes");
    // Each error event sets its own log bit; write one clears it
    for (int k = 0; k < 3; k++) begin
      evt[k] <= 1'b1;
      @(posedge clock);
      evt[k] <= 1'b0;
      @(posedge clock);
      cfg(lrr_pkg::OFS_RATE0, 1'b0, 8'h00, rd);
      check(rd[7:0], regv | (8'h10 << k));
      cfg(lrr_pkg::OFS_RATE0, 1'b1, regv | 8'h70, rd);
      cfg(lrr_pkg::OFS_RATE0, 1'b0, 8'h00, rd);
      check(rd[7:0], regv);
    end
    $display("end of test: error logs");
    // Control line held low: short select trips, long select trips only later
    for (int s = 0; s < 3; s++) begin
      regv[7] = (s != 0);
      cfg(lrr_pkg::OFS_RATE0, 1'b1, regv | 8'h70, rd);
      axi_wr(lrr_pkg::CTL_LINK, {23'h0, cur, 4'h8});
      repeat ((s == 0) ? 100 : (s == 1) ? 120 : 260) @(posedge clock);
      axi_wr(lrr_pkg::CTL_LINK, {23'h0, cur, 4'h0});
      cfg(lrr_pkg::OFS_RATE0, 1'b0, 8'h00, rd);
      check(rd[7:0], regv | ((s == 1) ? 8'h00 : 8'h10));
    end
    cfg(lrr_pkg::OFS_RATE0, 1'b1, regv | 8'h70, rd);
    $display("end of test: control timeout");
    // Rate writes refused once hardware link management is on
    axi_wr(lrr_pkg::CTL_LINK, {23'h0, cur, 4'h4});
    cfg(lrr_pkg::OFS_RATE0, 1'b1, regv ^ 8'h01, rd);
    check(rd[9], 1'b1);
    cfg(lrr_pkg::OFS_RATE0, 1'b0, 8'h00, rd);
    check(rd[7:0], regv);
    axi_wr(lrr_pkg::CTL_STAT, 32'h200);
    axi_rd(lrr_pkg::CTL_STAT, rd);
    check(rd[9], 1'b0);
    axi_wr(lrr_pkg::CTL_LINK, {23'h0, cur, 4'h0});
    $display("end of test: managed link");
    // Ends disagree on rate: training must not complete
    link_cycle(lrr_pkg::LNK_RST, cur, cur ^ 5'h01);
    check(lnk_if.peer_rate, cur ^ 5'h01);
    $display("end of test: rate mismatch");
    print_verdict();
  end

  // Watchdog well beyond the expected run of some 5000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
